// >>> rtl/pdt_timer.sv
// Purpose: 8-bit down timer with 7-bit down prescaler and tap select
// Assumes: Core access is synchronous; read data one cycle after rd
// Notes: Interrupt request is a level; wake request follows it
`timescale 1ns/1ps
module pdt_timer
	import pdt_pkg::*;
#(
	parameter int CLK_DIV = PDT_CLK_DIV
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Core data-space access
	input wire pdt_req_t bus_req,
	output logic [7:0] bus_rdata,
	// Interrupt and wake
	output logic timer_irq,
	output logic wake_req
);
	initial begin
		if (CLK_DIV != PDT_CLK_DIV) begin
			$error("pdt_timer: prescaler input divider is fixed");
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Prescaler input strobe

	logic pre_tick;

	pdt_tick_gen #(
		.DIV(CLK_DIV)
	) u_tick (
		.clk(clk),
		.resetn(resetn),
		.tick(pre_tick)
	);

	////////////////////////////////////////////////////////////////////////
	// Register state

	logic [6:0] psc_q;
	logic [6:0] psc_d;
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	pdt_ctl_t ctl_q;
	pdt_ctl_t ctl_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;

	// Access decode
	logic wr_psc;
	logic wr_cnt;
	logic wr_ctl;
	logic rd_any;

	always_comb begin
		wr_psc = 1'b0;
		wr_cnt = 1'b0;
		wr_ctl = 1'b0;
		if (bus_req.addr == PDT_OFF_PSC) begin
			wr_psc = bus_req.wr;
		end else if (bus_req.addr == PDT_OFF_CNT) begin
			wr_cnt = bus_req.wr;
		end else if (bus_req.addr == PDT_OFF_CTL) begin
			wr_ctl = bus_req.wr;
		end
		rd_any = bus_req.rd;
	end

	////////////////////////////////////////////////////////////////////////
	// Tap selection

	logic [6:0] psc_dec;
	logic [7:0] tap_edges;
	logic cnt_step;
	logic run;

	assign run = ctl_q.prescale_run;
	assign psc_dec = psc_q - 7'd1;

	// Rising edge of a down-counting bit: 0 now, 1 after the step
	always_comb begin
		tap_edges[0] = pre_tick;
		for (int i = 1; i < 8; i++) begin
			tap_edges[i] = pre_tick && !psc_q[i-1] && psc_dec[i-1];
		end
	end

	assign cnt_step = run && tap_edges[ctl_q.tap_select];

	////////////////////////////////////////////////////////////////////////
	// Prescaler and counter next values

	logic dec_to_zero;

	assign dec_to_zero = cnt_step && (cnt_q == 8'h00_01);

	always_comb begin
		psc_d = psc_q;
		if (!run) begin
			psc_d = PDT_PSC_RESET;
		end else if (wr_psc) begin
			psc_d = bus_req.wdata[6:0];
		end else if (pre_tick) begin
			psc_d = psc_dec;
		end
	end

	always_comb begin
		cnt_d = cnt_q;
		if (wr_cnt) begin
			cnt_d = bus_req.wdata;
		end else if (cnt_step) begin
			cnt_d = cnt_q - 8'd1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control/status next value

	logic flag_set;

	always_comb begin
		flag_set = 1'b0;
		if (dec_to_zero && !wr_cnt) begin
			flag_set = 1'b1;
		end
		if (wr_cnt && bus_req.wdata == PDT_CNT_ZERO) begin
			flag_set = 1'b1;
		end
		if (wr_ctl && bus_req.wdata[PDT_BIT_ZERO]) begin
			flag_set = 1'b1;
		end
	end

	always_comb begin
		ctl_d = ctl_q;
		if (wr_ctl) begin
			ctl_d = pdt_ctl_t'(bus_req.wdata);
		end
		if (flag_set) begin
			ctl_d.zero_reached_flag = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data

	always_comb begin
		rdata_d = 8'h00_00;
		if (rd_any) begin
			if (bus_req.addr == PDT_OFF_PSC) begin
				rdata_d = {1'b0, psc_q};
			end else if (bus_req.addr == PDT_OFF_CNT) begin
				rdata_d = cnt_q;
			end else if (bus_req.addr == PDT_OFF_CTL) begin
				rdata_d = ctl_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge clk) begin
		if (!resetn) begin
			psc_q <= PDT_PSC_RESET;
			cnt_q <= PDT_CNT_RESET;
			ctl_q <= pdt_ctl_t'(PDT_CTL_RESET);
			rdata_q <= 8'h00_00;
		end else begin
			psc_q <= psc_d;
			cnt_q <= cnt_d;
			ctl_q <= ctl_d;
			rdata_q <= rdata_d;
		end
	end

	assign bus_rdata = rdata_q;
	assign timer_irq = ctl_q.zero_reached_flag && ctl_q.zero_irq_enable;
	assign wake_req = timer_irq;

	////////////////////////////////////////////////////////////////////////
	// Checks

	a_tick_spacing: assert property (@(posedge clk) disable iff (!resetn)
		pre_tick |=> !pre_tick [*8])
		else $error("prescaler strobe came too soon");

	a_psc_forced: assert property (@(posedge clk) disable iff (!resetn)
		!run |=> (psc_q == PDT_PSC_RESET))
		else $error("prescaler not forced while stopped");

	a_cnt_stopped: assert property (@(posedge clk) disable iff (!resetn)
		(!run && !wr_cnt) |=> $stable(cnt_q))
		else $error("counter moved while stopped");

	a_div1_step: assert property (@(posedge clk) disable iff (!resetn)
		(run && ctl_q.tap_select == 3'd0 && pre_tick && !wr_cnt)
		|=> (cnt_q == $past(cnt_q) - 8'd1))
		else $error("counter missed a factor-one step");

	a_zero_flag: assert property (@(posedge clk) disable iff (!resetn)
		(cnt_step && cnt_q == 8'h00_01 && !wr_cnt)
		|=> (cnt_q == 8'h00_00) && ctl_q.zero_reached_flag)
		else $error("zero reached without flag");

	a_write_wins: assert property (@(posedge clk) disable iff (!resetn)
		(wr_cnt && dec_to_zero && bus_req.wdata != 8'h00_00 && !wr_ctl
		&& !ctl_q.zero_reached_flag)
		|=> (cnt_q == $past(bus_req.wdata)) && !ctl_q.zero_reached_flag)
		else $error("write lost to decrement");

	a_irq_gate: assert property (@(posedge clk) disable iff (!resetn)
		(flag_set && ctl_q.zero_irq_enable && !wr_ctl)
		|=> (timer_irq && wake_req))
		else $error("interrupt request not raised");

	a_psc_read: assert property (@(posedge clk) disable iff (!resetn)
		(rd_any && bus_req.addr == PDT_OFF_PSC)
		|=> (bus_rdata == {1'b0, $past(psc_q)}))
		else $error("prescaler read wrong");

	a_wrap_ff: assert property (@(posedge clk) disable iff (!resetn)
		(cnt_step && cnt_q == 8'h00_00 && !wr_cnt) |=> (cnt_q == 8'h00_FF))
		else $error("counter did not wrap");

	a_reset_vals: assert property (@(posedge clk)
		!resetn |=> (cnt_q == PDT_CNT_RESET) && (psc_q == PDT_PSC_RESET)
		&& (ctl_q == pdt_ctl_t'(PDT_CTL_RESET)))
		else $error("reset values wrong");

	a_tick_gap: assert property (@(posedge clk) disable iff (!resetn)
		pre_tick |-> ##12 pre_tick)
		else $error("prescaler strobe period wrong");

	a_psc_step: assert property (@(posedge clk) disable iff (!resetn)
		(run && pre_tick && !wr_psc)
		|=> (psc_q == $past(psc_q) - 7'd1))
		else $error("prescaler missed a step");

	a_psc_hold: assert property (@(posedge clk) disable iff (!resetn)
		(run && !pre_tick && !wr_psc) |=> $stable(psc_q))
		else $error("prescaler moved without strobe");

	a_psc_load: assert property (@(posedge clk) disable iff (!resetn)
		(run && wr_psc)
		|=> (psc_q == $past(bus_req.wdata[6:0])))
		else $error("prescaler load lost");

	a_psc_refuse: assert property (@(posedge clk) disable iff (!resetn)
		(!run && wr_psc)
		|=> (psc_q == PDT_PSC_RESET))
		else $error("prescaler loaded while stopped");

	a_cnt_load: assert property (@(posedge clk) disable iff (!resetn)
		wr_cnt |=> (cnt_q == $past(bus_req.wdata)))
		else $error("counter load lost");

	a_cnt_hold: assert property (@(posedge clk) disable iff (!resetn)
		(!cnt_step && !wr_cnt) |=> $stable(cnt_q))
		else $error("counter moved without tap edge");

	a_tap0_hold: assert property (@(posedge clk) disable iff (!resetn)
		(run && ctl_q.tap_select == 3'd0 && !pre_tick && !wr_cnt)
		|=> $stable(cnt_q))
		else $error("factor-one counter stepped early");

	a_tap1_rise: assert property (@(posedge clk) disable iff (!resetn)
		(run && ctl_q.tap_select == 3'd1 && pre_tick && !psc_q[0]
		&& !wr_cnt) |=> (cnt_q == $past(cnt_q) - 8'd1))
		else $error("factor-two tap missed a step");

	a_tap1_fall: assert property (@(posedge clk) disable iff (!resetn)
		(run && ctl_q.tap_select == 3'd1 && psc_q[0] && !wr_cnt)
		|=> $stable(cnt_q))
		else $error("factor-two tap stepped on falling bit");

	a_tap7_rise: assert property (@(posedge clk) disable iff (!resetn)
		(run && ctl_q.tap_select == 3'd7 && pre_tick && psc_q == 7'h00
		&& !wr_cnt) |=> (cnt_q == $past(cnt_q) - 8'd1))
		else $error("top tap missed a step");

	a_tap7_fall: assert property (@(posedge clk) disable iff (!resetn)
		(run && ctl_q.tap_select == 3'd7 && psc_q != 7'h00 && !wr_cnt)
		|=> $stable(cnt_q))
		else $error("top tap stepped early");

	a_flag_wr: assert property (@(posedge clk) disable iff (!resetn)
		(wr_ctl && bus_req.wdata[PDT_BIT_ZERO])
		|=> ctl_q.zero_reached_flag)
		else $error("status write did not set flag");

	a_flag_cnt0: assert property (@(posedge clk) disable iff (!resetn)
		(wr_cnt && bus_req.wdata == PDT_CNT_ZERO)
		|=> ctl_q.zero_reached_flag && (cnt_q == PDT_CNT_ZERO))
		else $error("zero load did not set flag");

	a_flag_clr: assert property (@(posedge clk) disable iff (!resetn)
		(wr_ctl && !bus_req.wdata[PDT_BIT_ZERO] && !dec_to_zero)
		|=> !ctl_q.zero_reached_flag)
		else $error("flag not cleared by write");

	a_ctl_hold: assert property (@(posedge clk) disable iff (!resetn)
		(!wr_ctl && !wr_cnt && !dec_to_zero) |=> $stable(ctl_q))
		else $error("status changed without cause");

	a_ctl_write: assert property (@(posedge clk) disable iff (!resetn)
		(wr_ctl && !dec_to_zero)
		|=> (ctl_q == pdt_ctl_t'($past(bus_req.wdata))))
		else $error("status write lost");

	a_irq_mask: assert property (@(posedge clk) disable iff (!resetn)
		(wr_ctl && !bus_req.wdata[PDT_BIT_IE])
		|=> !timer_irq)
		else $error("interrupt request not masked");

	a_cnt_read: assert property (@(posedge clk) disable iff (!resetn)
		(rd_any && bus_req.addr == PDT_OFF_CNT)
		|=> (bus_rdata == $past(cnt_q)))
		else $error("counter read wrong");

	a_ctl_read: assert property (@(posedge clk) disable iff (!resetn)
		(rd_any && bus_req.addr == PDT_OFF_CTL)
		|=> (pdt_ctl_t'(bus_rdata) == $past(ctl_q)))
		else $error("status read wrong");

	a_rd_idle: assert property (@(posedge clk) disable iff (!resetn)
		!rd_any |=> (bus_rdata == 8'h00_00))
		else $error("read data not idle");
endmodule

// >>> rtl/pdt_pkg.sv
// Purpose: Shared constants and types for the prescaled down timer
// Assumes: Core data-space access with 8-bit address and data
// Notes: Clock is the internal core frequency, 40 MHz
package pdt_pkg;
	// Register offsets in data space
	localparam logic [7:0] PDT_OFF_PSC = 8'h00_D2;
	localparam logic [7:0] PDT_OFF_CNT = 8'h00_D3;
	localparam logic [7:0] PDT_OFF_CTL = 8'h00_D4;
	// Reset values and the counter zero value
	localparam logic [6:0] PDT_PSC_RESET = 7'h00_7F;
	localparam logic [7:0] PDT_CNT_RESET = 8'h00_FF;
	localparam logic [7:0] PDT_CTL_RESET = 8'h00_00;
	localparam logic [7:0] PDT_CNT_ZERO = 8'h00_00;
	// Control/status field positions
	localparam int PDT_BIT_ZERO = 7;
	localparam int PDT_BIT_IE = 6;
	localparam int PDT_BIT_RSV1 = 5;
	localparam int PDT_BIT_FREE = 4;
	localparam int PDT_BIT_RUN = 3;
	localparam int PDT_TAP_MSB = 2;
	// Prescaler input divider and interrupt vector number
	localparam int PDT_CLK_DIV = 12;
	localparam int PDT_IRQ_VECTOR = 4;
	// Core access request
	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} pdt_req_t;
	// Control/status fields
	typedef struct packed {
		logic zero_reached_flag;
		logic zero_irq_enable;
		logic reserved_write_one;
		logic unused_position;
		logic prescale_run;
		logic [2:0] tap_select;
	} pdt_ctl_t;
endpackage

// >>> rtl/pdt_tick_gen.sv
// Purpose: One-cycle strobe every DIV clock cycles
// Assumes: Synchronous active-low reset
// Notes: Strobe stands for the prescaler input rising edge
`timescale 1ns/1ps
module pdt_tick_gen #(
	parameter int DIV = 12
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Strobe out
	output logic tick
);
	localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [W-1:0] LAST = W'(DIV - 1);

	initial begin
		if (DIV < 2) begin
			$error("pdt_tick_gen: DIV must be at least 2");
		end
	end

	logic [W-1:0] div_q;
	logic [W-1:0] div_d;

	always_comb begin
		if (div_q == LAST) begin
			div_d = '0;
		end else begin
			div_d = div_q + W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			div_q <= '0;
		end else begin
			div_q <= div_d;
		end
	end

	assign tick = (div_q == LAST);
endmodule

// >>> dv/testbench.sv
// Purpose: Self-checking bench for the prescaled down timer
// Assumes: Core access as in the timer hand-over contract
// Notes: Strobe phase is found by polling the prescaler
`timescale 1ns/1ps
module testbench;
	import pdt_pkg::*;
	logic clk;
	logic resetn;
	pdt_req_t bus_req;
	logic [7:0] bus_rdata;
	logic timer_irq;
	logic wake_req;
	int err_total;
	int n_tests;
	int cyc;
	logic [7:0] d;
	logic [7:0] v;
	logic [7:0] nv;
	logic [7:0] c;
	logic [8:0] e9;

	pdt_timer dut (.clk(clk), .resetn(resetn), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .timer_irq(timer_irq), .wake_req(wake_req));

	////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic end_of_test();
		$display("tests %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			end_of_test();
		end
	end

	////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [7:0] w);
		@(posedge clk);
		bus_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: w};
		@(posedge clk);
		bus_req.wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		bus_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00_00};
		@(posedge clk);
		bus_req.rd <= 1'b0;
		#1 d = bus_rdata;
	endtask

	task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
		rd(a);
		n_tests++;
		if (d !== e) begin
			err_total++;
			$display("[FAIL] t=%0t got %h exp %h", $time, d, e);
		end
	endtask

	task automatic chk_pin(input logic e);
		#1 n_tests++;
		if ({timer_irq, wake_req} !== {e, e}) begin
			err_total++;
			$display("[FAIL] t=%0t got %h exp %h", $time,
				{timer_irq, wake_req}, {e, e});
		end
	endtask

	// Returns just after a prescaler step is seen
	task automatic sync();
		logic [7:0] p;
		rd(PDT_OFF_PSC);
		p = d;
		do rd(PDT_OFF_PSC); while (d === p);
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		resetn = 1'b0;
		bus_req = '0;
		err_total = 0;
		n_tests = 0;
		cyc = 0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		chk_reg(PDT_OFF_PSC, 8'h00_7F);
		chk_reg(PDT_OFF_CNT, 8'h00_FF);
		chk_reg(PDT_OFF_CTL, 8'h00_00);
		chk_reg(8'h00_D5, 8'h00_00);
		chk_pin(1'b0);
		// Every tap, counter steps modelled from prescaler bit edges
		for (int t = 0; t < 8; t++) begin
			wr(PDT_OFF_CTL, 8'h00_28 | 8'(t));
			sync();
			v = 8'h00_7F & (8'h00_01 << t);
			c = 8'h00_80;
			wr(PDT_OFF_PSC, v | 8'h00_80);
			wr(PDT_OFF_CNT, c);
			repeat (3) begin
				sync();
				nv = (v - 8'h00_01) & 8'h00_7F;
				e9 = {~v & nv, 1'b1};
				if (e9[t]) begin
					c = c - 8'h00_01;
				end
				v = nv;
			end
			chk_reg(PDT_OFF_PSC, v);
			chk_reg(PDT_OFF_CNT, c);
			chk_reg(PDT_OFF_CTL, 8'h00_28 | 8'(t));
		end
		// Zero reach, interrupt, clear, wrap
		wr(PDT_OFF_CTL, 8'h00_68);
		sync();
		wr(PDT_OFF_CNT, 8'h00_01);
		sync();
		chk_reg(PDT_OFF_CNT, 8'h00_00);
		chk_reg(PDT_OFF_CTL, 8'h00_E8);
		chk_pin(1'b1);
		wr(PDT_OFF_CTL, 8'h00_68);
		chk_pin(1'b0);
		sync();
		chk_reg(PDT_OFF_CNT, 8'h00_FF);
		chk_reg(PDT_OFF_CTL, 8'h00_68);
		// Software sets of the flag, enable masking
		wr(PDT_OFF_CTL, 8'h00_A8);
		chk_pin(1'b0);
		chk_reg(PDT_OFF_CTL, 8'h00_A8);
		wr(PDT_OFF_CTL, 8'h00_28);
		wr(PDT_OFF_CNT, 8'h00_00);
		chk_reg(PDT_OFF_CTL, 8'h00_A8);
		// Stop: prescaler forced, nothing runs
		wr(PDT_OFF_CTL, 8'h00_20);
		chk_reg(PDT_OFF_PSC, 8'h00_7F);
		rd(PDT_OFF_CNT);
		c = d;
		wr(PDT_OFF_PSC, 8'h00_11);
		repeat (40) @(posedge clk);
		chk_reg(PDT_OFF_PSC, 8'h00_7F);
		chk_reg(PDT_OFF_CNT, c);
		// Mid-run reset, then a load racing the drop to zero
		wr(PDT_OFF_CTL, 8'h00_E8);
		@(posedge clk);
		resetn <= 1'b0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		chk_reg(PDT_OFF_CTL, 8'h00_00);
		chk_pin(1'b0);
		wr(PDT_OFF_CTL, 8'h00_28);
		wr(PDT_OFF_CNT, 8'h00_02);
		repeat (16) @(posedge clk);
		wr(PDT_OFF_CNT, 8'h00_55);
		chk_reg(PDT_OFF_CNT, 8'h00_55);
		chk_reg(PDT_OFF_CTL, 8'h00_28);
		chk_reg(PDT_OFF_PSC, 8'h00_7D);
		end_of_test();
	end
endmodule
